// file: sar_adc_pkg.sv
// package of shared constants and types, plus the two-flop synchroniser.
// assumes one system clock and a host-driven serial link clock.

package sar_adc_pkg;

    // ------------------------------------------------------------
    // frame and word geometry
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 12;
    localparam int FALL_CNT_BITS = 7;
    localparam logic [6:0] CONV_FALLS = 7'h0F;
    localparam logic [6:0] CAL_PU_FALLS = 7'h18;
    localparam logic [6:0] CAL_NORM_FALLS = 7'h40;
    localparam logic [6:0] FIRST_FALL = 7'h01;
    localparam logic [6:0] LAST_BIT_FALL = 7'h0C;
    localparam logic [11:0] SAR_START = 12'h800;
    localparam logic [11:0] RESULT_ZERO = 12'h000;
    localparam logic [3:0] SAR_TOP_BIT = 4'hB;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int MIN_ACQ_TIME_NS = 80;
    localparam int ACQ_CYCLES_INT =
        (MIN_ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ACQ_CYCLES =
        (ACQ_CYCLES_INT < 1) ? 4'h1 : 4'(ACQ_CYCLES_INT);
    localparam logic [1:0] CAL_BIT_CYCLES = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ACQUIRE_STATE = 3'h1,
        CONVERT_STATE = 3'h2,
        OFFSET_CALIBRATE_STATE = 3'h4
    } conv_state_type;

    // events raised on the link clock, each as a toggle
    typedef struct packed {
        logic conv_done_tgl;
        logic cal_req_tgl;
    } link_event_type;

endpackage

`timescale 1ns/10ps

// ------------------------------------------------------------
// two-flop level synchroniser
// ------------------------------------------------------------
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_clk) begin
        meta_reg <= i_d;
        o_q <= meta_reg;
    end
endmodule

// file: sar_adc_frame_controller.sv
// frame and state control of a serial-output sar converter.
// assumes the host drives chip select and serial clock; the comparator
// outputs settle before the clock edge that samples them.

`timescale 1ns/10ps

module sar_adc_frame_controller (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sclk,
    input wire logic i_cmp_conv,
    input wire logic i_cmp_cal,
    output logic o_sdo,
    output logic o_sdo_oe_b,
    output logic [11:0] o_sar_code,
    output logic [11:0] o_cal_code,
    output logic o_inputs_connected,
    output logic [2:0] o_state,
    output logic [11:0] o_offset,
    output logic o_acq_ready
);

    // ------------------------------------------------------------
    // link reset and frame clear
    // ------------------------------------------------------------
    logic link_rst_b_reg;
    logic link_clr_b;
    logic sclk_n;
    always_ff @(posedge i_clk_sys) begin
        link_rst_b_reg <= i_rst_b;
    end

    // counters and shifter clear while no frame is open
    assign link_clr_b = link_rst_b_reg & ~i_cs_b;
    assign sclk_n = ~i_sclk;
    // the pin is released the moment chip select rises, with no clock
    assign o_sdo_oe_b = i_cs_b;

    // ------------------------------------------------------------
    // link domain: falling-edge count
    // ------------------------------------------------------------
    logic [6:0] fall_cnt_reg;
    logic [6:0] fall_cnt_next;

    assign fall_cnt_next = (fall_cnt_reg == sar_adc_pkg::CAL_NORM_FALLS) ?
                           fall_cnt_reg : fall_cnt_reg + 7'h01;

    always_ff @(negedge i_sclk or negedge link_clr_b) begin
        if (!link_clr_b) begin
            fall_cnt_reg <= 7'h00;
        end else begin
            fall_cnt_reg <= fall_cnt_next;
        end
    end

    logic started_reg;
    logic first_frame_reg;

    always_ff @(negedge i_sclk or negedge link_rst_b_reg) begin
        if (!link_rst_b_reg) begin
            started_reg <= 1'b0;
            first_frame_reg <= 1'b1;
        end else if (fall_cnt_next == sar_adc_pkg::FIRST_FALL &&
                     fall_cnt_reg != sar_adc_pkg::FIRST_FALL) begin
            started_reg <= 1'b1;
            if (started_reg) begin
                first_frame_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: successive approximation on falls 1 to 12
    // ------------------------------------------------------------
    logic [11:0] sar_code_reg;
    logic [11:0] sar_code_next;
    logic [3:0] sar_bit;
    logic sar_active;

    assign sar_active = (fall_cnt_next <= sar_adc_pkg::LAST_BIT_FALL) &&
                        (fall_cnt_reg < sar_adc_pkg::LAST_BIT_FALL);
    assign sar_bit = 4'(sar_adc_pkg::LAST_BIT_FALL - fall_cnt_next);

    always_comb begin
        sar_code_next = sar_code_reg;
        if (sar_active) begin
            if (!i_cmp_conv) begin
                sar_code_next[sar_bit] = 1'b0;
            end
            if (sar_bit != 4'h0) begin
                sar_code_next[sar_bit - 4'h1] = 1'b1;
            end
        end
    end

    // trial code starts at mid scale at the sampling instant
    always_ff @(negedge i_sclk or negedge link_clr_b) begin
        if (!link_clr_b) begin
            sar_code_reg <= sar_adc_pkg::SAR_START;
        end else begin
            sar_code_reg <= sar_code_next;
        end
    end

    assign o_sar_code = sar_code_reg;

    // ------------------------------------------------------------
    // link domain: offset word taken over from the system side
    // ------------------------------------------------------------
    logic [11:0] offset_reg;
    logic offset_tgl_reg;
    logic offset_tgl_sync;
    logic offset_seen_reg;
    logic [11:0] offset_link_reg;

    sync2 #(
        .WIDTH(1)
    ) u_sync_offset (
        .i_clk(sclk_n),
        .i_d(offset_tgl_reg),
        .o_q(offset_tgl_sync)
    );

    // the word stands still long before its toggle arrives here
    always_ff @(negedge i_sclk or negedge link_rst_b_reg) begin
        if (!link_rst_b_reg) begin
            offset_seen_reg <= 1'b0;
            offset_link_reg <= sar_adc_pkg::RESULT_ZERO;
        end else if (offset_tgl_sync != offset_seen_reg) begin
            offset_seen_reg <= offset_tgl_sync;
            offset_link_reg <= offset_reg;
        end
    end

    logic [11:0] prev_result_reg;
    logic [11:0] corrected;
    logic cal_at_fall;
    sar_adc_pkg::link_event_type link_event_reg;
    assign corrected = (sar_code_reg > offset_link_reg) ?
                       sar_code_reg - offset_link_reg :
                       sar_adc_pkg::RESULT_ZERO;
    assign cal_at_fall = (fall_cnt_reg != fall_cnt_next) &&
        (fall_cnt_next == (first_frame_reg ? sar_adc_pkg::CAL_PU_FALLS :
        sar_adc_pkg::CAL_NORM_FALLS));

    // a short frame never stores, so the next frame shows stale data
    always_ff @(negedge i_sclk or negedge link_rst_b_reg) begin
        if (!link_rst_b_reg) begin
            prev_result_reg <= sar_adc_pkg::RESULT_ZERO;
            link_event_reg <= '0;
        end else begin
            if (fall_cnt_next == sar_adc_pkg::CONV_FALLS &&
                fall_cnt_reg != sar_adc_pkg::CONV_FALLS) begin
                prev_result_reg <= corrected;
                link_event_reg.conv_done_tgl <=
                    ~link_event_reg.conv_done_tgl;
            end
            // chip select rising first means no toggle: abort
            if (cal_at_fall) begin
                link_event_reg.cal_req_tgl <=
                    ~link_event_reg.cal_req_tgl;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: serial data launch on rising edges
    // ------------------------------------------------------------
    logic [11:0] out_word;
    logic [3:0] out_bit;

    // first frame, and so a power-up calibration frame, sends zeros
    assign out_word = first_frame_reg ? sar_adc_pkg::RESULT_ZERO :
                      prev_result_reg;
    assign out_bit = 4'(sar_adc_pkg::LAST_BIT_FALL - fall_cnt_reg);

    always_ff @(posedge i_sclk or negedge link_clr_b) begin
        if (!link_clr_b) begin
            o_sdo <= 1'b0;
        end else if (fall_cnt_reg >= sar_adc_pkg::FIRST_FALL &&
                     fall_cnt_reg <= sar_adc_pkg::LAST_BIT_FALL) begin
            o_sdo <= out_word[out_bit];
        end else begin
            o_sdo <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // system domain: crossings in
    // ------------------------------------------------------------
    logic cs_sync;
    logic cmp_cal_sync;
    sar_adc_pkg::link_event_type event_sync;
    sar_adc_pkg::link_event_type event_last_reg;
    logic cs_prev_reg;
    logic cs_fall;
    logic cs_rise;
    logic conv_seen;
    logic cal_seen;

    sync2 #(
        .WIDTH(2)
    ) u_sync_pins (
        .i_clk(i_clk_sys),
        .i_d({i_cs_b, i_cmp_cal}),
        .o_q({cs_sync, cmp_cal_sync})
    );
    sync2 #(
        .WIDTH(2)
    ) u_sync_events (
        .i_clk(i_clk_sys),
        .i_d(link_event_reg),
        .o_q(event_sync)
    );

    always_ff @(posedge i_clk_sys) begin
        event_last_reg <= event_sync;
        if (!i_rst_b) begin
            cs_prev_reg <= 1'b1;
        end else begin
            cs_prev_reg <= cs_sync;
        end
    end

    assign cs_fall = cs_prev_reg & ~cs_sync;
    assign cs_rise = ~cs_prev_reg & cs_sync;
    assign conv_seen = event_sync.conv_done_tgl !=
                       event_last_reg.conv_done_tgl;
    assign cal_seen = event_sync.cal_req_tgl != event_last_reg.cal_req_tgl;

    // ------------------------------------------------------------
    // system domain: offset calibration search
    // ------------------------------------------------------------
    sar_adc_pkg::conv_state_type state_reg;
    sar_adc_pkg::conv_state_type state_next;
    logic [3:0] cal_bit_reg;
    logic [1:0] cal_wait_reg;
    logic cal_done;
    logic [11:0] cal_decided;

    assign cal_done = (state_reg == sar_adc_pkg::OFFSET_CALIBRATE_STATE) &&
                      (cal_wait_reg == 2'h0) && (cal_bit_reg == 4'h0);

    always_comb begin
        cal_decided = o_cal_code;
        if (!cmp_cal_sync) begin
            cal_decided[cal_bit_reg] = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_cal_code <= sar_adc_pkg::SAR_START;
            cal_bit_reg <= sar_adc_pkg::SAR_TOP_BIT;
            cal_wait_reg <= sar_adc_pkg::CAL_BIT_CYCLES;
            offset_reg <= sar_adc_pkg::RESULT_ZERO;
            offset_tgl_reg <= 1'b0;
        end else if (state_reg != sar_adc_pkg::OFFSET_CALIBRATE_STATE) begin
            o_cal_code <= sar_adc_pkg::SAR_START;
            cal_bit_reg <= sar_adc_pkg::SAR_TOP_BIT;
            cal_wait_reg <= sar_adc_pkg::CAL_BIT_CYCLES;
        end else if (cal_wait_reg != 2'h0) begin
            cal_wait_reg <= cal_wait_reg - 2'h1;
        end else if (cal_bit_reg == 4'h0) begin
            // kept until the next calibration finishes or a reset clears it
            offset_reg <= cal_decided;
            offset_tgl_reg <= ~offset_tgl_reg;
        end else begin
            o_cal_code <= cal_decided;
            o_cal_code[cal_bit_reg - 4'h1] <= 1'b1;
            cal_bit_reg <= cal_bit_reg - 4'h1;
            cal_wait_reg <= sar_adc_pkg::CAL_BIT_CYCLES;
        end
    end

    assign o_offset = offset_reg;

    // ------------------------------------------------------------
    // system domain: converter state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sar_adc_pkg::ACQUIRE_STATE: begin
                if (cal_seen) begin
                    state_next = sar_adc_pkg::OFFSET_CALIBRATE_STATE;
                end else if (cs_fall) begin
                    state_next = sar_adc_pkg::CONVERT_STATE;
                end
            end
            sar_adc_pkg::CONVERT_STATE: begin
                if (cal_seen) begin
                    state_next = sar_adc_pkg::OFFSET_CALIBRATE_STATE;
                end else if (conv_seen || cs_rise) begin
                    state_next = sar_adc_pkg::ACQUIRE_STATE;
                end
            end
            sar_adc_pkg::OFFSET_CALIBRATE_STATE: begin
                if (cal_done) begin
                    state_next = sar_adc_pkg::ACQUIRE_STATE;
                end
            end
            default: begin
                state_next = sar_adc_pkg::ACQUIRE_STATE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state_reg <= sar_adc_pkg::ACQUIRE_STATE;
            o_inputs_connected <= 1'b1;
        end else begin
            state_reg <= state_next;
            o_inputs_connected <=
                (state_next == sar_adc_pkg::ACQUIRE_STATE);
        end
    end

    assign o_state = state_reg;

    // acquisition settle indicator
    logic [3:0] acq_cnt_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            acq_cnt_reg <= 4'h0;
            o_acq_ready <= 1'b0;
        end else if (state_reg != sar_adc_pkg::ACQUIRE_STATE) begin
            acq_cnt_reg <= 4'h0;
            o_acq_ready <= 1'b0;
        end else if (acq_cnt_reg != sar_adc_pkg::ACQ_CYCLES) begin
            acq_cnt_reg <= acq_cnt_reg + 4'h1;
        end else begin
            o_acq_ready <= 1'b1;
        end
    end

endmodule

// file: sar_adc_frame_controller_monitor.sv
// checker of the frame controller ports, bound to its top module.
// assumes the host serial clock stands still between frames.
`timescale 1ns/10ps
module sar_adc_frame_controller_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sclk,
    input wire logic o_sdo,
    input wire logic o_sdo_oe_b,
    input wire logic o_inputs_connected,
    input wire logic [2:0] o_state,
    input wire logic [11:0] o_offset,
    input wire logic o_acq_ready
);
    localparam logic [2:0] ST_ACQUIRE = sar_adc_pkg::ACQUIRE_STATE;
    localparam logic [2:0] ST_CONVERT = sar_adc_pkg::CONVERT_STATE;
    localparam logic [2:0] ST_CALIB = sar_adc_pkg::OFFSET_CALIBRATE_STATE;
    // ------------------------------------------------------------
    // falls counted within a frame
    // ------------------------------------------------------------
    logic [6:0] fall_cnt_reg;
    always_ff @(negedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            fall_cnt_reg <= 7'h00;
        end else if (fall_cnt_reg != 7'h7F) begin
            fall_cnt_reg <= fall_cnt_reg + 7'h01;
        end
    end
    chk_oe_follows_cs: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) o_sdo_oe_b == i_cs_b)
        else $error("sdo enable differs from chip select");
    chk_sdo_idle_low: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) i_cs_b |-> !o_sdo)
        else $error("sdo not cleared outside a frame");
    chk_reset_state: assert property (
        @(posedge i_clk_sys) !i_rst_b |=> o_state == ST_ACQUIRE)
        else $error("reset does not give acquire");
    chk_lead_zero: assert property (
        @(negedge i_sclk) disable iff (i_cs_b || !i_rst_b)
        fall_cnt_reg == 7'h00 |-> !o_sdo) else $error("no leading zero");
    chk_tail_zeros: assert property (
        @(negedge i_sclk) disable iff (i_cs_b || !i_rst_b)
        fall_cnt_reg >= 7'h0D |-> !o_sdo) else $error("tail bit not zero");
    chk_convert_entry: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        $fell(i_cs_b) && o_state == ST_ACQUIRE |-> ##[1:5]
        o_state == ST_CONVERT) else $error("frame start not converting");
    chk_convert_ends: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) o_state == ST_CONVERT
        |-> ##[1:40] o_state != ST_CONVERT) else $error("convert hangs");
    chk_calib_returns: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) o_state == ST_CALIB
        |-> ##[1:120] o_state == ST_ACQUIRE) else $error("calib hangs");
    chk_calib_disconnect: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) o_state == ST_CALIB &&
        $past(o_state) == ST_CALIB |-> !o_inputs_connected)
        else $error("inputs connected in calibration");
    chk_offset_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) $changed(o_offset)
        |-> $past(o_state) == ST_CALIB) else $error("offset moved");
    chk_ready_wait: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_b) o_acq_ready |->
        $past(o_state) == ST_ACQUIRE && $past(o_state, 2) == ST_ACQUIRE)
        else $error("ready before acquisition time");
endmodule

bind sar_adc_frame_controller sar_adc_frame_controller_monitor mon (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b),
    .i_sclk(i_sclk), .o_sdo(o_sdo), .o_sdo_oe_b(o_sdo_oe_b),
    .o_inputs_connected(o_inputs_connected), .o_state(o_state),
    .o_offset(o_offset), .o_acq_ready(o_acq_ready));

// file: sar_adc_host_model.sv
// host model: chip select, serial clock and the two comparators.
// assumes the bench starts one frame at a time.
`timescale 1ns/10ps
module sar_adc_host_model (
    input wire logic i_sdo,
    input wire logic [11:0] i_sar_code,
    input wire logic [11:0] i_cal_code,
    output logic o_cs_b,
    output logic o_sclk,
    output logic o_cmp_conv,
    output logic o_cmp_cal
);
    logic [11:0] analog_level = 12'h000;
    logic [11:0] cal_level = 12'h000;
    logic [63:0] capture = 64'h0;
    // input at or above the trial code answers one
    assign o_cmp_conv = (analog_level >= i_sar_code);
    // inputs disconnected: only the internal offset is compared
    assign o_cmp_cal = (cal_level >= i_cal_code);
    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
    end
    // one frame at a 30 ns clock; the clock stands still low outside it
    task automatic run_frame(input int falls, input bit slow);
        o_cs_b = 1'b0;
        capture = 64'h0;
        // a late first edge moves the link phase against the system clock
        #(slow ? 37 : 15);
        repeat (falls) begin
            o_sclk = 1'b1;
            #15;
            o_sclk = 1'b0;
            capture = {capture[62:0], i_sdo};
            #15;
        end
        o_cs_b = 1'b1;
    endtask
endmodule

// file: sar_adc_frame_controller_bench.sv
// self-checking bench of the frame controller with a host model.
// assumes the package, the checker and the host model come first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module sar_adc_frame_controller_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic cs_b, sclk, cmp_conv, cmp_cal, sdo, sdo_oe_b, connected, ready;
    logic [11:0] sar_code, cal_code, offset, prev_word, off, v;
    logic [2:0] state;
    logic [31:0] lfsr_reg = 32'h0000_3A9B;
    logic cal_seen = 1'b0;
    int err_count = 0;
    int compares = 0;
    int k;
    always #20 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        if (state == sar_adc_pkg::OFFSET_CALIBRATE_STATE) cal_seen <= 1'b1;
    end
    sar_adc_frame_controller dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_cs_b(cs_b), .i_sclk(sclk), .i_cmp_conv(cmp_conv),
        .i_cmp_cal(cmp_cal), .o_sdo(sdo), .o_sdo_oe_b(sdo_oe_b),
        .o_sar_code(sar_code), .o_cal_code(cal_code),
        .o_inputs_connected(connected), .o_state(state), .o_offset(offset),
        .o_acq_ready(ready));
    sar_adc_host_model host (.i_sdo(sdo), .i_sar_code(sar_code),
        .i_cal_code(cal_code), .o_cs_b(cs_b), .o_sclk(sclk),
        .o_cmp_conv(cmp_conv), .o_cmp_cal(cmp_cal));
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
    endfunction
    // leading zero, then the word, then zeros, as captured on falls
    function automatic logic [63:0] exp_stream(input logic [11:0] w,
            input int n);
        logic [63:0] s;
        s = {52'h0, w};
        return (n >= 13) ? s << (n - 13) : s >> (13 - n);
    endfunction
    function automatic logic [11:0] sat_sub(input logic [11:0] a, b);
        return (a > b) ? a - b : 12'h000;
    endfunction
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_ready();
        int i;
        repeat (8) @(posedge i_clk_sys);
        for (i = 0; i < 400 && ready !== 1'b1; i++) @(posedge i_clk_sys);
        if (i >= 400) begin
            err_count++;
            $display("mismatch acq_ready exp 1 got %b", ready);
            test_done();
        end
    endtask
    task automatic do_frame(input int n, input logic [11:0] a, input bit chk,
            input string nm);
        #1;
        host.analog_level = a;
        cal_seen = 1'b0;
        host.run_frame(n, lfsr_reg[7]);
        lfsr_reg = lfsr_next(lfsr_reg);
        if (chk) `CHK(nm, exp_stream(prev_word, n), host.capture);
        if (n >= 15) prev_word = sat_sub(a, off);
        wait_ready();
        $display("test %s done", nm);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge i_clk_sys);
        #1 i_rst_b = 1'b1;
        `CHK("state", sar_adc_pkg::ACQUIRE_STATE, state);
        `CHK("connected", 1'b1, connected);
        `CHK("sdo_oe_b", 1'b1, sdo_oe_b);
        prev_word = 12'h000;
        off = 12'h000;
        wait_ready();
        do_frame(20, lfsr_reg[11:0], 1'b1, "first_abort");
        `CHK("cal_seen", 1'b0, cal_seen);
        @(posedge i_clk_sys);
        #1 i_rst_b = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        #1 i_rst_b = 1'b1;
        prev_word = 12'h000;
        host.cal_level = {6'h00, lfsr_reg[5:0]};
        wait_ready();
        do_frame(24, 12'h123, 1'b1, "power_cal");
        `CHK("cal_seen", 1'b1, cal_seen);
        off = host.cal_level;
        `CHK("offset", off, offset);
        do_frame(16, 12'hFFF, 1'b0, "resync");
        for (k = 0; k < 10; k++) begin
            v = (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : lfsr_reg[11:0];
            do_frame(15 + int'(lfsr_reg[14:12]), v, 1'b1, "conv");
        end
        do_frame(8, 12'h5A5, 1'b1, "short");
        do_frame(16, 12'h3C3, 1'b1, "after_short");
        do_frame(40, 12'h0F0, 1'b1, "cal_abort");
        `CHK("cal_seen", 1'b0, cal_seen);
        host.cal_level = {6'h00, lfsr_reg[5:0]} + 12'h001;
        do_frame(64, 12'h7FF, 1'b1, "normal_cal");
        `CHK("cal_seen", 1'b1, cal_seen);
        off = host.cal_level;
        `CHK("offset", off, offset);
        do_frame(16, 12'h800, 1'b0, "resync");
        do_frame(16, 12'h456, 1'b1, "post_cal");
        test_done();
    end
endmodule
